// [rtl/dzq_pkg.sv]
package dzq_pkg;
	// reference clock and link clock ratio
	localparam int REF_PS         = 40000;  // ref_clk period, 25 MHz
	localparam int CK_HALF_REF    = 4;      // ref cycles per link half period
	localparam int CK_PS          = 2 * CK_HALF_REF * REF_PS;

	// asynchronous termination delays, longest times round down
	localparam int T_AONPD_MAX_PS = 8500;
	localparam int T_AOFPD_MAX_PS = 8500;
	localparam int AONPD_CYC      = (T_AONPD_MAX_PS / REF_PS < 1) ? 1 :
	                                T_AONPD_MAX_PS / REF_PS;
	localparam int AOFPD_CYC      = (T_AOFPD_MAX_PS / REF_PS < 1) ? 1 :
	                                T_AOFPD_MAX_PS / REF_PS;

	// power-down window figures, least times round up to link cycles
	localparam int T_CPDED_CK     = 1;
	localparam int T_XPDLL_PS     = 24000;
	localparam int XPDLL_NCK      = 10;
	localparam int XPDLL_CEIL     = (T_XPDLL_PS + CK_PS - 1) / CK_PS;
	localparam int XPDLL_CK       = (XPDLL_CEIL > XPDLL_NCK) ? XPDLL_CEIL :
	                                XPDLL_NCK;
	localparam int T_RFC_PS       = 350000;
	localparam int RFC_CK         = (T_RFC_PS + CK_PS - 1) / CK_PS;
	localparam int T_XS_PS        = 360000;
	localparam int XS_CK          = (T_XS_PS + CK_PS - 1) / CK_PS;

	// calibration windows in link cycles
	localparam int ZQINIT_CK      = 512;
	localparam int ZQOPER_CK      = 256;
	localparam int ZQCS_CK        = 64;
	localparam int CNT_W          = 10;

	// mode register fields
	localparam int MR0_DLL_PD_BIT = 12;
	localparam int MR0_CL_LSB     = 4;
	localparam int MR1_AL_LSB     = 3;
	localparam int MR2_CWL_LSB    = 3;
	localparam int ZQ_LONG_BIT    = 10;
	localparam int CL_BASE        = 4;
	localparam int CWL_BASE       = 5;
	localparam int ODTL_OFFSET    = 2;
	localparam logic [2:0] BA_MR0 = 3'h0;
	localparam logic [2:0] BA_MR1 = 3'h1;
	localparam logic [2:0] BA_MR2 = 3'h2;

	// mode register reset values
	localparam logic       DLL_PD_RST   = 1'h0;
	localparam logic [2:0] CL_CODE_RST  = 3'h1;
	localparam logic [1:0] AL_CODE_RST  = 2'h0;
	localparam logic [2:0] CWL_CODE_RST = 3'h0;

	// pin command codes {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] CMD_NOP = 4'h7;
	localparam logic [3:0] CMD_MRS = 4'h0;
	localparam logic [3:0] CMD_REF = 4'h1;
	localparam logic [3:0] CMD_ZQ  = 4'h6;

	typedef enum logic [2:0] {
		OP_MRS  = 3'b000,
		OP_REF  = 3'b001,
		OP_ZQCL = 3'b010,
		OP_ZQCS = 3'b011,
		OP_PDE  = 3'b100,
		OP_PDX  = 3'b101,
		OP_SRE  = 3'b110,
		OP_SRX  = 3'b111
	} dzq_op_t;
endpackage

// [rtl/dzq_link_if.sv]
`timescale 1ns/1ps
interface dzq_link_if;
	logic        ck;
	logic        cke;
	logic        cs_n;
	logic        ras_n;
	logic        cas_n;
	logic        we_n;
	logic        odt;
	logic [2:0]  ba;
	logic [12:0] addr;

	modport ctrl (output ck, cke, cs_n, ras_n, cas_n, we_n, odt, ba, addr);
	modport dram (input ck, cke, cs_n, ras_n, cas_n, we_n, odt, ba, addr);
endinterface

// [rtl/dzq_dram_end.sv]
`timescale 1ns/1ps
// Operation
// - frozen-DLL power-down uses asynchronous termination
// - asynchronous path ignores additive latency
// - async turn-on within power-down on-delay
// - async turn-off within power-down off-delay
// - frozen DLL gives power-down entry window
// - entry window ends after tCPDED
// - pending refresh stretches entry window to tRFC
// - window end cycle counts as inside
// - window turn-on bounded by both on-delays
// - window turn-off bounded by both off-delays
// - exit window lasts tXPDLL after CKE high
// - overlapping windows merge into one span
// - long calibration runs engine, then transfers
// - first long in tZQinit, later tZQoper
// - short calibration finishes within tZQCS
// - controller keeps channel quiet during calibration
// - calibration current off once finished
// - controller issues no activates, so all banks stay precharged for calibration
// - no self calibration on self-refresh exit
// - controller holds calibration commands for tXS after self-refresh exit
// - controller holds CKE high, ODT low during calibration
// - sync termination after CWL+AL-2 cycles
module dzq_dram_end import dzq_pkg::*; (
	input  wire logic        ref_clk,
	input  wire logic        arst_n,
	dzq_link_if.dram         link,
	output logic             rtt_on,
	output logic             rtt_uncertain,
	output logic             async_mode,
	output logic             zq_busy,
	output logic             zq_current_on,
	output logic             cal_update,
	output logic [3:0]       cal_code
);
	localparam int PIN_W = 23;

	logic [PIN_W-1:0] pin_s1;
	logic [PIN_W-1:0] pin_s2;
	logic             ck_q;
	logic             cke_q;
	logic             odt_q;
	logic             dll_pd;
	logic [2:0]       cl_code;
	logic [1:0]       al_code;
	logic [2:0]       cwl_code;
	logic [31:0]      odt_pipe;
	logic             pd;
	logic [CNT_W-1:0] entry_cnt;
	logic [CNT_W-1:0] exit_cnt;
	logic [CNT_W-1:0] rfc_cnt;
	logic [CNT_W-1:0] zq_cnt;
	logic             zq_first;
	logic             zq_long;
	logic             pend;
	logic [7:0]       dly;

	// all link pins, link clock included, pass two flops together so
	// the sampled command stays aligned with the sampled clock edge
	wire logic [PIN_W-1:0] pins = {link.ck, link.cke, link.cs_n,
		link.ras_n, link.cas_n, link.we_n, link.odt, link.ba, link.addr};

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_s1 <= '0;
			pin_s2 <= '0;
			ck_q   <= 1'b0;
		end else begin
			pin_s1 <= pins;
			pin_s2 <= pin_s1;
			ck_q   <= pin_s2[22];
		end
	end

	// field selection and command decode from the synchronised pins
	wire logic        ck_rise = pin_s2[22] & ~ck_q;
	wire logic        cke_p   = pin_s2[21];
	wire logic [3:0]  cmd_p   = pin_s2[20:17];
	wire logic        odt_p   = pin_s2[16];
	wire logic [2:0]  ba_p    = pin_s2[15:13];
	wire logic [12:0] addr_p  = pin_s2[12:0];
	wire logic        live    = ck_rise & cke_q & cke_p;
	wire logic        mrs_hit = live & (cmd_p == CMD_MRS);
	wire logic        ref_hit = ck_rise & cke_q & (cmd_p == CMD_REF);
	wire logic        zq_hit  = live & (cmd_p == CMD_ZQ) & ~zq_busy;
	wire logic        cke_dn  = ck_rise & cke_q & ~cke_p;
	wire logic        cke_up  = ck_rise & ~cke_q & cke_p;
	wire logic        frozen  = ~dll_pd;

	// latencies: wl = cwl + al, odtl = wl - 2
	wire logic [4:0] cl_v   = 5'(cl_code) + 5'(CL_BASE);
	wire logic [4:0] cwl_v  = 5'(cwl_code) + 5'(CWL_BASE);
	wire logic [4:0] al_v   = (al_code == 2'h1) ? cl_v - 5'h01 :
	                          (al_code == 2'h2) ? cl_v - 5'h02 : 5'h00;
	wire logic [4:0] odtl   = cwl_v + al_v - 5'(ODTL_OFFSET);
	wire logic       sync_t = odt_pipe[odtl - 5'h01];

	// entry window may be stretched by a refresh still running
	wire logic [CNT_W-1:0] cpded_v = CNT_W'(T_CPDED_CK);
	wire logic [CNT_W-1:0] entry_v =
		(rfc_cnt > cpded_v) ? rfc_cnt : cpded_v;
	wire logic window  = (entry_cnt != '0) | (exit_cnt != '0);
	wire logic asel    = async_mode | window;
	wire logic [7:0] dly_ld = odt_q ? 8'(AONPD_CYC) : 8'(AOFPD_CYC);

	// sampled clock enable, sampled termination request, mode registers
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cke_q    <= 1'b0;
			odt_q    <= 1'b0;
			odt_pipe <= '0;
			dll_pd   <= DLL_PD_RST;
			cl_code  <= CL_CODE_RST;
			al_code  <= AL_CODE_RST;
			cwl_code <= CWL_CODE_RST;
		end else begin
			if (ck_rise) begin
				cke_q    <= cke_p;
				odt_q    <= odt_p;
				odt_pipe <= {odt_pipe[30:0], odt_p};
			end
			if (mrs_hit && ba_p == BA_MR0) begin
				dll_pd  <= addr_p[MR0_DLL_PD_BIT];
				cl_code <= addr_p[MR0_CL_LSB +: 3];
			end
			if (mrs_hit && ba_p == BA_MR1)
				al_code <= addr_p[MR1_AL_LSB +: 2];
			if (mrs_hit && ba_p == BA_MR2)
				cwl_code <= addr_p[MR2_CWL_LSB +: 3];
		end
	end

	// power-down state; a refresh with cke low is self-refresh, which
	// is not a precharge power-down and keeps the synchronous timing
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pd         <= 1'b0;
			async_mode <= 1'b0;
		end else begin
			if (cke_dn)
				pd <= (cmd_p != CMD_REF);
			else if (cke_up)
				pd <= 1'b0;
			async_mode <= pd & frozen;
		end
	end

	// refresh busy time, read when cke drops
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			rfc_cnt <= '0;
		else if (ref_hit)
			rfc_cnt <= CNT_W'(RFC_CK);
		else if (ck_rise && rfc_cnt != '0)
			rfc_cnt <= rfc_cnt - 1'b1;
	end

	// transition windows count link cycles; the cycle cke is first
	// registered is the first inside, the end cycle is still inside
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			entry_cnt     <= '0;
			exit_cnt      <= '0;
			rtt_uncertain <= 1'b0;
		end else begin
			if (cke_dn && frozen && cmd_p != CMD_REF)
				entry_cnt <= entry_v;
			else if (ck_rise && entry_cnt != '0)
				entry_cnt <= entry_cnt - 1'b1;
			if (cke_up && pd && frozen)
				exit_cnt <= CNT_W'(XPDLL_CK);
			else if (ck_rise && exit_cnt != '0)
				exit_cnt <= exit_cnt - 1'b1;
			rtt_uncertain <= window;
		end
	end

	// termination: synchronous pipe when settled, otherwise the
	// asynchronous timer; inside a window the async timer satisfies
	// the earliest and latest bounds of both modes at this clock rate
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rtt_on <= 1'b0;
			pend   <= 1'b0;
			dly    <= '0;
		end else if (!asel) begin
			pend <= 1'b0;
			if (ck_rise)
				rtt_on <= sync_t;
		end else if (pend) begin
			if (dly == 8'h01) begin
				rtt_on <= odt_q;
				pend   <= 1'b0;
			end else begin
				dly <= dly - 8'h01;
			end
		end else if (odt_q != rtt_on) begin
			// no additive latency on this path
			if (dly_ld == 8'h01) begin
				rtt_on <= odt_q;
			end else begin
				pend <= 1'b1;
				dly  <= dly_ld - 8'h01;
			end
		end
	end

	// calibration engine; only an explicit command starts it, so a
	// self-refresh exit leaves the codes alone
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			zq_cnt   <= '0;
			zq_first <= 1'b1;
			zq_long  <= 1'b0;
		end else if (zq_hit) begin
			zq_long <= addr_p[ZQ_LONG_BIT];
			if (!addr_p[ZQ_LONG_BIT])
				zq_cnt <= CNT_W'(ZQCS_CK);
			else if (zq_first)
				zq_cnt <= CNT_W'(ZQINIT_CK);
			else
				zq_cnt <= CNT_W'(ZQOPER_CK);
			if (addr_p[ZQ_LONG_BIT])
				zq_first <= 1'b0;
		end else if (ck_rise && zq_cnt != '0) begin
			zq_cnt <= zq_cnt - 1'b1;
		end
	end

	// last cycle of the window transfers the result to the io; long
	// calibration moves the code further since it starts from scratch
	wire logic xfer = ck_rise & (zq_cnt == {{(CNT_W-1){1'b0}}, 1'b1});

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			zq_busy       <= 1'b0;
			zq_current_on <= 1'b0;
			cal_update    <= 1'b0;
			cal_code      <= '0;
		end else begin
			zq_busy       <= zq_hit | (zq_cnt != '0 && !xfer);
			zq_current_on <= zq_hit | (zq_cnt != '0 && !xfer);
			cal_update    <= xfer;
			if (xfer)
				cal_code <= cal_code + (zq_long ? 4'h2 : 4'h1);
		end
	end
endmodule // dzq_dram_end

// [rtl/dzq_ctrl_end.sv]
`timescale 1ns/1ps
module dzq_ctrl_end import dzq_pkg::*; (
	input  wire logic        ref_clk,
	input  wire logic        arst_n,
	dzq_link_if.ctrl         link,
	input  wire logic        cmd_valid,
	input  wire dzq_op_t     cmd_op,
	input  wire logic [2:0]  cmd_ba,
	input  wire logic [12:0] cmd_addr,
	input  wire logic        odt_req,
	output logic             cmd_ready,
	output logic             zq_quiet
);
	logic [1:0]       div;
	logic             pend;
	dzq_op_t          pend_op;
	logic [2:0]       pend_ba;
	logic [12:0]      pend_addr;
	logic [CNT_W-1:0] zq_cnt;
	logic [CNT_W-1:0] xs_cnt;
	logic             zq_first;
	logic [3:0]       next_cmd;
	logic             next_cke;
	logic [12:0]      next_addr;

	// pins change on the same ref edge on which the link clock falls, half a period
	// ahead of the rising edge on which the device samples them
	wire logic half_end  = (div == 2'(CK_HALF_REF - 1));
	wire logic fall_slot = half_end & link.ck;
	wire logic zq_op     = (pend_op == OP_ZQCL) | (pend_op == OP_ZQCS);
	wire logic issue     = fall_slot & pend & ~(zq_op & xs_cnt != '0);
	wire logic accept    = cmd_valid & cmd_ready;
	wire logic zq_issue  = issue & zq_op;
	wire logic next_pend = accept | (pend & ~issue);
	wire logic [CNT_W-1:0] zq_load =
		(pend_op == OP_ZQCS) ? CNT_W'(ZQCS_CK) :
		zq_first ? CNT_W'(ZQINIT_CK) : CNT_W'(ZQOPER_CK);
	wire logic [CNT_W-1:0] next_zq = zq_issue ? zq_load :
		(fall_slot && zq_cnt != '0) ? zq_cnt - 1'b1 : zq_cnt;

	// pin values for the pending operation
	always_comb begin
		next_cmd  = CMD_NOP;
		next_cke  = link.cke;
		next_addr = pend_addr;
		if (issue) begin
			unique case (pend_op)
				OP_MRS:  next_cmd = CMD_MRS;
				OP_REF:  next_cmd = CMD_REF;
				OP_ZQCL: begin
					next_cmd = CMD_ZQ;
					next_addr[ZQ_LONG_BIT] = 1'b1;
				end
				OP_ZQCS: begin
					next_cmd = CMD_ZQ;
					next_addr[ZQ_LONG_BIT] = 1'b0;
				end
				OP_PDE:  next_cke = 1'b0;
				OP_PDX:  next_cke = 1'b1;
				OP_SRE: begin
					next_cmd = CMD_REF;
					next_cke = 1'b0;
				end
				OP_SRX:  next_cke = 1'b1;
			endcase
		end
	end

	// link clock divider
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			div     <= '0;
			link.ck <= 1'b0;
		end else begin
			div <= half_end ? 2'h0 : div + 2'h1;
			if (half_end)
				link.ck <= ~link.ck;
		end
	end

	// one request held until its slot; calibration waits for tXS
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pend      <= 1'b0;
			pend_op   <= OP_MRS;
			pend_ba   <= '0;
			pend_addr <= '0;
			cmd_ready <= 1'b0;
		end else begin
			pend <= next_pend;
			if (accept) begin
				pend_op   <= cmd_op;
				pend_ba   <= cmd_ba;
				pend_addr <= cmd_addr;
			end
			// no new request while calibrating keeps the channel quiet
			cmd_ready <= ~next_pend & (next_zq == '0);
		end
	end

	// guard counters in link cycles
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			zq_cnt   <= '0;
			xs_cnt   <= '0;
			zq_first <= 1'b1;
			zq_quiet <= 1'b0;
		end else begin
			zq_cnt   <= next_zq;
			zq_quiet <= next_zq != '0;
			if (zq_issue && pend_op == OP_ZQCL)
				zq_first <= 1'b0;
			if (issue && pend_op == OP_SRX)
				xs_cnt <= CNT_W'(XS_CK);
			else if (fall_slot && xs_cnt != '0)
				xs_cnt <= xs_cnt - 1'b1;
		end
	end

	// command pins; termination forced off while calibrating
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			link.cke   <= 1'b0;
			link.cs_n  <= 1'b1;
			link.ras_n <= 1'b1;
			link.cas_n <= 1'b1;
			link.we_n  <= 1'b1;
			link.odt   <= 1'b0;
			link.ba    <= '0;
			link.addr  <= '0;
		end else if (fall_slot) begin
			link.cke <= next_cke;
			{link.cs_n, link.ras_n, link.cas_n, link.we_n} <= next_cmd;
			link.odt  <= odt_req & (next_zq == '0);
			link.ba   <= pend_ba;
			link.addr <= next_addr;
		end
	end
endmodule // dzq_ctrl_end

// [dv/dzq_link_chk.sv]
`timescale 1ns/1ps
// watches the shared link and the device end's outputs
module dzq_link_chk import dzq_pkg::*; (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic odt,
	input wire logic rtt_on,
	input wire logic rtt_uncertain,
	input wire logic async_mode,
	input wire logic zq_busy,
	input wire logic zq_current_on
);
	localparam int ZQ_LIM  = (ZQINIT_CK + 4) * 2 * CK_HALF_REF;
	localparam int UNC_LIM = (XPDLL_CK + RFC_CK + 4) * 2 * CK_HALF_REF;
	logic [12:0] busy_cnt;
	wire         zq_cmd;
	wire  [12:0] next_busy_cnt;

	// calibration command decode and run length
	assign zq_cmd        = cke && ({cs_n, ras_n, cas_n, we_n} == CMD_ZQ);
	assign next_busy_cnt = zq_busy ? busy_cnt + 13'h1 : 13'h0;

	// ref cycles of the current calibration; longest run fits in 13 bits
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			busy_cnt <= 13'h0;
		else
			busy_cnt <= next_busy_cnt;
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	chk_zq_start: assert property ($rose(zq_cmd) |-> ##[1:16] zq_busy)
		else $error("calibration did not start");
	chk_quiet_chan: assert property ($fell(cs_n) |-> !zq_busy)
		else $error("command during calibration");
	chk_cal_odt_low: assert property (zq_busy |-> !odt)
		else $error("odt high during calibration");
	chk_cal_cke_high: assert property (zq_busy |-> cke)
		else $error("cke low during calibration");
	chk_current_off: assert property ($fell(zq_busy) |-> ##[0:2] !zq_current_on)
		else $error("calibration current left on");
	chk_zq_len: assert property (busy_cnt <= 13'(ZQ_LIM))
		else $error("calibration too long");
	chk_async_pd: assert property (cke && $past(cke, 8) && $past(cke, 16)
		|-> !async_mode)
		else $error("async mode outside power-down");
	chk_async_follow: assert property ((async_mode || rtt_uncertain) &&
		$changed(odt) |-> ##[7:9] (rtt_on == odt))
		else $error("termination slow in async path");
	chk_window_start: assert property ($rose(async_mode) |-> ##[0:2] rtt_uncertain)
		else $error("no entry window");
	chk_window_end: assert property ($rose(rtt_uncertain) |->
		##[1:UNC_LIM] !rtt_uncertain)
		else $error("window never ended");

	cover property ($rose(zq_busy));
	cover property ($rose(async_mode));
	cover property ($rose(rtt_uncertain));
endmodule // dzq_link_chk

// [dv/dram_odt_mode_and_zq_calibration_tb.sv]
`timescale 1ns/1ps
module dram_odt_mode_and_zq_calibration_tb import dzq_pkg::*;;
	logic        ref_clk;
	logic        arst_n;
	logic        cmd_valid;
	dzq_op_t     cmd_op;
	logic [2:0]  cmd_ba;
	logic [12:0] cmd_addr;
	logic        odt_req;
	logic        cmd_ready;
	logic        zq_quiet;
	logic        rtt_on;
	logic        rtt_uncertain;
	logic        async_mode;
	logic        zq_busy;
	logic        zq_current_on;
	logic        cal_update;
	logic [3:0]  cal_code;
	logic [3:0]  exp_code;
	logic        first_done;
	logic        unc_seen;
	int          upd_cnt;
	int          n_fail;
	int          compares;
	int          k;

	dzq_link_if dzq_link_if_i ();
	dzq_ctrl_end dzq_ctrl_end_i (.ref_clk(ref_clk), .arst_n(arst_n),
		.link(dzq_link_if_i.ctrl), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
		.cmd_ba(cmd_ba), .cmd_addr(cmd_addr), .odt_req(odt_req),
		.cmd_ready(cmd_ready), .zq_quiet(zq_quiet));
	dzq_dram_end dzq_dram_end_i (.ref_clk(ref_clk), .arst_n(arst_n),
		.link(dzq_link_if_i.dram), .rtt_on(rtt_on),
		.rtt_uncertain(rtt_uncertain), .async_mode(async_mode),
		.zq_busy(zq_busy), .zq_current_on(zq_current_on),
		.cal_update(cal_update), .cal_code(cal_code));
	dzq_link_chk dzq_link_chk_i (.ref_clk(ref_clk), .arst_n(arst_n),
		.cke(dzq_link_if_i.cke), .cs_n(dzq_link_if_i.cs_n),
		.ras_n(dzq_link_if_i.ras_n), .cas_n(dzq_link_if_i.cas_n),
		.we_n(dzq_link_if_i.we_n), .odt(dzq_link_if_i.odt),
		.rtt_on(rtt_on), .rtt_uncertain(rtt_uncertain),
		.async_mode(async_mode), .zq_busy(zq_busy),
		.zq_current_on(zq_current_on));

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	// sticky window flag and update count, sampled where outputs are settled
	always @(negedge ref_clk) begin
		if (rtt_uncertain === 1'b1)
			unc_seen = 1'b1;
		if (cal_update === 1'b1)
			upd_cnt++;
	end

	function automatic logic [3:0] next_code(input logic [3:0] c,
		input logic lng);
		return lng ? c + 4'h2 : c + 4'h1;
	endfunction

	task automatic chk(input string what, input logic [3:0] exp,
		input logic [3:0] got);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	// request held until a falling edge shows ready, taken at the next rise
	task automatic do_op(input dzq_op_t op, input logic [2:0] ba,
		input logic [12:0] a);
		int n;
		n = 0;
		@(negedge ref_clk);
		cmd_valid = 1'b1;
		cmd_op = op;
		cmd_ba = ba;
		cmd_addr = a;
		while (cmd_ready !== 1'b1 && n < 6000) begin
			@(negedge ref_clk);
			n++;
		end
		chk("ready in time", 4'h1, 4'(n < 6000));
		@(negedge ref_clk);
		cmd_valid = 1'b0;
	endtask

	// one calibration; random address bits other than the long/short select
	task automatic zq(input logic lng);
		int n;
		int nck;
		logic [12:0] a;
		n = 0;
		nck = lng ? (first_done ? ZQOPER_CK : ZQINIT_CK) : ZQCS_CK;
		a = 13'($urandom) & 13'h1BFF;
		a[ZQ_LONG_BIT] = lng;
		// no activates are ever issued, so all banks stay precharged
		do_op(lng ? OP_ZQCL : OP_ZQCS, 3'h0, a);
		if (lng)
			first_done = 1'b1;
		chk("ready while busy", 4'h0, 4'(cmd_ready));
		wt(10);
		chk("zq_quiet on", 4'h1, 4'(zq_quiet));
		while (cal_update !== 1'b1 && n < 6000) begin
			@(negedge ref_clk);
			n++;
		end
		exp_code = next_code(exp_code, lng);
		wt(3);
		chk("zq time", 4'h1, 4'(n >= nck * 8 - 8 && n <= nck * 8 + 48));
		chk("cal_code", exp_code, cal_code);
		chk("zq current", 4'h0, 4'(zq_current_on));
		chk("zq_quiet off", 4'h0, 4'(zq_quiet));
	endtask

	task automatic stop_test;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// the longest run is a handful of calibrations, far below this span
	initial begin
		#(40 * 40000);
		n_fail++;
		stop_test;
	end

	initial begin
		arst_n = 1'b0;
		cmd_valid = 1'b0;
		cmd_op = OP_MRS;
		cmd_ba = 3'h0;
		cmd_addr = 13'h0;
		odt_req = 1'b0;
		exp_code = 4'h0;
		first_done = 1'b0;
		unc_seen = 1'b0;
		upd_cnt = 0;
		n_fail = 0;
		compares = 0;
		void'($urandom(41));
		wt(2);
		arst_n = 1'b1;
		// cke is low out of reset, so leave power-down first
		do_op(OP_PDX, 3'h0, 13'h0);
		wt(120);
		zq(1'b1);
		zq(1'b1);
		zq(1'b0);
		for (k = 0; k < 4; k++)
			zq(1'($urandom));
		// additive latency CL-1 delays the synchronous path to 7 link cycles
		do_op(OP_MRS, BA_MR1, 13'h0008);
		odt_req = 1'b1;
		wt(32);
		chk("sync rtt early", 4'h0, 4'(rtt_on));
		wt(60);
		chk("sync rtt on", 4'h1, 4'(rtt_on));
		odt_req = 1'b0;
		wt(100);
		unc_seen = 1'b0;
		do_op(OP_PDE, 3'h0, 13'h0);
		wt(24);
		chk("async mode", 4'h1, 4'(async_mode));
		wt(40);
		chk("entry window seen", 4'h1, 4'(unc_seen));
		chk("entry window over", 4'h0, 4'(rtt_uncertain));
		odt_req = 1'b1;
		wt(20);
		chk("async rtt on", 4'h1, 4'(rtt_on));
		odt_req = 1'b0;
		wt(20);
		chk("async rtt off", 4'h0, 4'(rtt_on));
		do_op(OP_PDX, 3'h0, 13'h0);
		wt(16);
		chk("exit window", 4'h1, 4'(rtt_uncertain));
		wt((XPDLL_CK + 2) * 8);
		chk("exit window over", 4'h0, 4'(rtt_uncertain));
		chk("sync again", 4'h0, 4'(async_mode));
		// short power-down: entry and exit windows must merge
		do_op(OP_PDE, 3'h0, 13'h0);
		do_op(OP_PDX, 3'h0, 13'h0);
		k = 0;
		while (rtt_uncertain !== 1'b1 && k < 300) begin
			wt(1);
			k++;
		end
		k = 0;
		while (rtt_uncertain === 1'b1 && k < 300) begin
			wt(1);
			k++;
		end
		// longer than the exit window alone: entry cycle must join it
		chk("merged window", 4'h1,
			4'(k >= (XPDLL_CK + T_CPDED_CK) * 8 - 4));
		k = upd_cnt;
		do_op(OP_SRE, 3'h0, 13'h0);
		wt(80);
		do_op(OP_SRX, 3'h0, 13'h0);
		wt(200);
		chk("no self calibration", 4'h0, 4'(upd_cnt - k));
		chk("no self busy", 4'h0, 4'(zq_busy));
		zq(1'b0);
		stop_test;
	end
endmodule // dram_odt_mode_and_zq_calibration_tb
